// >>> sim/sts_checker.sv
`timescale 1ns/10ps
`include "sts_regs.vh"

module sts_checker (
    // clock and reset
    input wire logic                       ref_clk,
    input wire logic                       rstn,
    // apb slave
    input wire logic                       psel,
    input wire logic                       penable,
    input wire logic                       pwrite,
    input wire logic [11:0]                paddr,
    input wire logic [31:0]                pwdata,
    input wire logic [31:0]                prdata,
    input wire logic                       pready,
    input wire logic                       pslverr,
    // timer events
    input wire logic [`STS_NUM_TIMERS-1:0] count_tick,
    input wire logic [`STS_NUM_TIMERS-1:0] overflow
);
    // ----------------------------------------------------------------
    // shadow of both mode registers, rebuilt from completed writes
    // ----------------------------------------------------------------
    logic [7:0] m1_reg;
    logic [7:0] m2_reg;
    wire        wr_done = psel && penable && pready && pwrite;
    wire  [5:0] halt = {m2_reg[6], m2_reg[5], m2_reg[3], m2_reg[2], m1_reg[3], m1_reg[2]};

    always @(posedge ref_clk) begin
        if (!rstn) begin
            m1_reg <= 8'h00;
            m2_reg <= 8'h00;
        end else if (wr_done && paddr[11:2] == `STS_IDX_MODE1) begin
            m1_reg <= pwdata[7:0];
        end else if (wr_done && paddr[11:2] == `STS_IDX_MODE2) begin
            m2_reg <= pwdata[7:0];
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);

    // a pulse taken just before the halt landed may still show, hence both cycles
    property p_halt_blocks;
        (count_tick & halt & $past(halt)) == 6'h00;
    endproperty
    a_halt_blocks: assert property (p_halt_blocks) else $error("halted timer ticked");
    property p_ovf_tick;
        (overflow & ~count_tick) == 6'h00;
    endproperty
    a_ovf_tick: assert property (p_ovf_tick) else $error("overflow without tick");
    property p_t2_chain;
        overflow[0] && !m1_reg[1] && m1_reg[4] && !m1_reg[3] |=> count_tick[1];
    endproperty
    a_t2_chain: assert property (p_t2_chain) else $error("timer two missed chain");
    property p_t4_chain;
        overflow[2] && m2_reg[4:1] == 4'h0 |=> count_tick[3];
    endproperty
    a_t4_chain: assert property (p_t4_chain) else $error("timer four missed chain");
    property p_t5_t2;
        overflow[1] && m2_reg[7] && !m1_reg[6] && !m2_reg[5] |=> count_tick[4];
    endproperty
    a_t5_t2: assert property (p_t5_t2) else $error("timer five missed two");
    property p_t5_t4;
        overflow[3] && m2_reg[7] && m1_reg[6] && !m2_reg[5] |=> count_tick[4];
    endproperty
    a_t5_t4: assert property (p_t5_t4) else $error("timer five missed four");
    property p_t6_chain;
        overflow[4] && m1_reg[7] && !m2_reg[6] |=> count_tick[5];
    endproperty
    a_t6_chain: assert property (p_t6_chain) else $error("timer six missed chain");
    property p_ready;
        psel && penable && !pready |=> pready ##1 !pready;
    endproperty
    a_ready: assert property (p_ready) else $error("bad ready pulse");
    property p_err;
        pslverr |-> pready && psel && penable;
    endproperty
    a_err: assert property (p_err) else $error("error outside access");
endmodule

bind sts_top sts_checker u_chk (
    .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .count_tick(count_tick), .overflow(overflow)
);

// >>> sim/sts_top_tb_top.sv
`timescale 1ns/10ps
`include "sts_regs.vh"

`define CHK(got, exp) begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
        n_errors++; \
        $display("unexpected at %0t: got %0h expected %0h", $time, got, exp); \
    end \
end

module sts_top_tb_top;
    // ----------------------------------------------------------------
    // stimulus, observation and the design
    // ----------------------------------------------------------------
    logic        ref_clk = 1'b0;
    logic        rstn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h00000000;
    logic [3:0]  src = 4'h0;
    wire  [31:0] prdata;
    wire         pready;
    wire         pslverr;
    wire  [5:0]  count_tick;
    wire  [5:0]  overflow;
    int          n_errors = 0;
    int          tests_run = 0;
    int          n_tick[6];

    // narrow counters so that chained overflows come every four ticks
    sts_top #(.TMR_W(2)) u_dut (
        .ref_clk(ref_clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .main_osc_input(src[0]), .sub_osc_input(src[1]), .ext_count_pin_a(src[2]),
        .ext_count_pin_b(src[3]), .count_tick(count_tick), .overflow(overflow)
    );

    always #10 ref_clk = ~ref_clk;

    always @(posedge ref_clk) begin
        for (int i = 0; i < 6; i++) begin
            if (count_tick[i] === 1'b1) begin
                n_tick[i]++;
            end
        end
    end

    task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d,
                       output logic [31:0] rd, output logic err);
        @(posedge ref_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'h0};
        pwdata <= {24'h000000, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        // no local limit: a missing pready is left to the watchdog, which fails the run
        do begin
            @(posedge ref_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, idx, d, r, e);
    endtask

    task automatic rd_chk(input logic [9:0] idx, input logic [7:0] x, input logic xe);
        logic [31:0] r;
        logic        e;
        apb(1'b0, idx, 8'h00, r, e);
        `CHK(r, {24'h000000, x})
        `CHK(e, xe)
    endtask

    // osc and pins toggle together, eight clocks a period, well under the sampling limit
    task automatic run(input logic [7:0] m1, input logic [7:0] m2, input logic [7:0] t3x,
                       input logic [7:0] cfg, input logic [3:0] drv, input int k,
                       input logic [5:0][9:0] e);
        rstn <= 1'b0;
        repeat (2) @(posedge ref_clk);
        rstn <= 1'b1;
        wr(`STS_IDX_MODE1, m1);
        wr(`STS_IDX_MODE2, m2);
        wr(`STS_IDX_T3EXT, t3x);
        wr(`STS_IDX_CLKCFG, cfg);
        n_tick = '{default: 0};
        repeat (k) begin
            repeat (4) @(posedge ref_clk);
            src <= drv;
            repeat (4) @(posedge ref_clk);
            src <= 4'h0;
        end
        repeat (12) @(posedge ref_clk);
        for (int i = 0; i < 6; i++) begin
            `CHK(n_tick[i], int'(e[i]))
        end
        $display("test done: modes %0h %0h source %0h", m1, m2, drv);
    endtask

    task conclude;
        $display("checks %0d, mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge ref_clk);
        n_errors++;
        conclude();
    end

    initial begin
        repeat (4) @(posedge ref_clk);
        rstn <= 1'b1;
        rd_chk(`STS_IDX_MODE1, 8'h00, 1'b0);
        rd_chk(`STS_IDX_MODE2, 8'h00, 1'b0);
        wr(`STS_IDX_MODE1, 8'hA5);
        wr(`STS_IDX_MODE2, 8'h5A);
        rd_chk(`STS_IDX_MODE1, 8'hA5, 1'b0);
        rd_chk(`STS_IDX_MODE2, 8'h5A, 1'b0);
        // only the sub-clock select bit of the extra register is kept
        wr(`STS_IDX_T3EXT, 8'hFF);
        rd_chk(`STS_IDX_T3EXT, 8'h40, 1'b0);
        rd_chk(10'h000, 8'h00, 1'b1);
        $display("test done: registers");
        run(8'h00, 8'h00, 8'h00, 8'h00, 4'h1, 64,
            {10'h004, 10'h004, 10'h001, 10'h004, 10'h004, 10'h004});
        // timer four counted one overflow of timer three and holds that value
        rd_chk(`STS_IDX_CNT_BASE + 10'h003, 8'h01, 1'b0);
        run(8'h0C, 8'h6C, 8'h00, 8'h00, 4'hF, 64,
            {10'h000, 10'h000, 10'h000, 10'h000, 10'h000, 10'h000});
        run(8'hE3, 8'h91, 8'h00, 8'h00, 4'hD, 64,
            {10'h002, 10'h008, 10'h020, 10'h040, 10'h040, 10'h040});
        run(8'h10, 8'h92, 8'h40, 8'h00, 4'h3, 256,
            {10'h010, 10'h001, 10'h100, 10'h100, 10'h004, 10'h010});
        run(8'h00, 8'h00, 8'h00, 8'h01, 4'h2, 64,
            {10'h004, 10'h004, 10'h001, 10'h004, 10'h004, 10'h004});
        run(8'h00, 8'h00, 8'h00, 8'h00, 4'h2, 64,
            {10'h000, 10'h000, 10'h000, 10'h000, 10'h000, 10'h000});
        run(8'h01, 8'h00, 8'h00, 8'h00, 4'h1, 4096,
            {10'h100, 10'h100, 10'h040, 10'h100, 10'h100, 10'h001});
        conclude();
    end
endmodule

// >>> verilog/sts_regs.vh
`ifndef STS_REGS_VH
`define STS_REGS_VH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define STS_IDX_MODE1      10'h0F4
`define STS_IDX_MODE2      10'h0F5
`define STS_IDX_T3EXT      10'h0C7
`define STS_IDX_CLKCFG     10'h0C6
`define STS_IDX_CNT_BASE   10'h0D0
`define STS_NUM_TIMERS     6

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define STS_RST_MODE1      8'h00
`define STS_RST_MODE2      8'h00
`define STS_RST_T3EXT      8'h00
`define STS_RST_CLKCFG     8'h00

// ----------------------------------------------------------------
// timer_mode_first fields
// ----------------------------------------------------------------
`define STS_T1_SRC_PRIMARY   0
`define STS_T2_SRC_PRIMARY   1
`define STS_T1_HALT          2
`define STS_T2_HALT          3
`define STS_T2_SRC_SECONDARY 4
`define STS_T1_SRC_SECONDARY 5
`define STS_T5_SRC_SECONDARY 6
`define STS_T6_SRC_INTERNAL  7

// ----------------------------------------------------------------
// timer_mode_second fields
// ----------------------------------------------------------------
`define STS_T3_SRC_LOW       0
`define STS_T4_SRC_LOW       1
`define STS_T3_HALT          2
`define STS_T4_HALT          3
`define STS_T4_SRC_HIGH      4
`define STS_T5_HALT          5
`define STS_T6_HALT          6
`define STS_T5_SRC_PRIMARY   7

// ----------------------------------------------------------------
// other fields
// ----------------------------------------------------------------
`define STS_T3_SUB_SEL       6
`define STS_SYS_SUB_SEL      0

// ----------------------------------------------------------------
// prescaler
// ----------------------------------------------------------------
`define STS_PRE_W            12
`define STS_PRE_DIV2_MASK    12'h001
`define STS_PRE_DIV16_MASK   12'h00F
`define STS_PRE_DIV4096_MASK 12'hFFF

`endif

// >>> verilog/sts_sync.v
`timescale 1ns/10ps

// ----------------------------------------------------------------
// three-stage synchroniser with agreement filter and rise pulse
// ----------------------------------------------------------------
module sts_sync (
    // clock and reset
    input  wire ref_clk,
    input  wire rstn,
    // pin side
    input  wire async_in,
    // core side
    output reg  rise_pulse
);

    reg s1_reg;
    reg s2_reg;
    reg s3_reg;
    reg level_reg;

    // a change is taken only once stages two and three agree
    always @(posedge ref_clk) begin
        if (!rstn) begin
            s1_reg     <= 1'b0;
            s2_reg     <= 1'b0;
            s3_reg     <= 1'b0;
            level_reg  <= 1'b0;
            rise_pulse <= 1'b0;
        end else begin
            s1_reg     <= async_in;
            s2_reg     <= s1_reg;
            s3_reg     <= s2_reg;
            rise_pulse <= 1'b0;
            if ((s2_reg == s3_reg) && (s2_reg != level_reg)) begin
                level_reg  <= s2_reg;
                rise_pulse <= s2_reg;
            end
        end
    end

endmodule

// >>> verilog/sts_top.v
`timescale 1ns/10ps
`include "sts_regs.vh"

// Contract
// - timer one: primary clear gives clock/16, set defers to secondary bit.
// - timer one secondary: clear gives clock/4096, set gives first pin.
// - timer two: primary set gives first pin; else clock/16 or timer one overflow.
// - timer five secondary: clear takes timer two, set timer four overflow.
// - timer five primary bit 7: clear gives clock/16, set defers to secondary.
// - timer six internal bit: clear gives clock/16, set timer five overflow.
// - timer three: 00 clock/16, 10 sub clock, any low bit set second pin.
// - timer four: 00 timer three overflow, 01 /16, 10 /2, 11 sub clock.
module sts_top #(
    parameter TMR_W = 8
) (
    // clock and reset
    input  wire                          ref_clk,
    input  wire                          rstn,
    // apb slave
    input  wire                          psel,
    input  wire                          penable,
    input  wire                          pwrite,
    input  wire [11:0]                   paddr,
    input  wire [31:0]                   pwdata,
    output reg  [31:0]                   prdata,
    output reg                           pready,
    output reg                           pslverr,
    // oscillator and count pins
    input  wire                          main_osc_input,
    input  wire                          sub_osc_input,
    input  wire                          ext_count_pin_a,
    input  wire                          ext_count_pin_b,
    // timer events
    output reg  [`STS_NUM_TIMERS-1:0]    count_tick,
    output reg  [`STS_NUM_TIMERS-1:0]    overflow
);

    localparam NT = `STS_NUM_TIMERS;

    reg  [7:0]          timer_mode_first_reg;
    reg  [7:0]          timer_mode_second_reg;
    reg  [7:0]          t3_ext_reg;
    reg  [7:0]          clk_cfg_reg;
    reg  [`STS_PRE_W-1:0] pre_reg;
    reg  [NT*TMR_W-1:0] cnt_reg;
    reg  [NT-1:0]       src;
    reg  [NT-1:0]       halt;
    reg  [NT-1:0]       adv;
    reg  [31:0]         rd_next;
    reg                 hit_next;
    reg  [9:0]          cnt_off;
    wire                main_edge;
    wire                sub_edge;
    wire                pin_a_edge;
    wire                pin_b_edge;
    wire                osc_tick;
    wire                div2;
    wire                div16;
    wire                div4096;
    wire [9:0]          idx;
    wire                wr_done;
    integer             i;
    integer             j;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    sts_sync u_sync_main (
        .ref_clk    (ref_clk),
        .rstn       (rstn),
        .async_in   (main_osc_input),
        .rise_pulse (main_edge)
    );

    sts_sync u_sync_sub (
        .ref_clk    (ref_clk),
        .rstn       (rstn),
        .async_in   (sub_osc_input),
        .rise_pulse (sub_edge)
    );

    sts_sync u_sync_pin_a (
        .ref_clk    (ref_clk),
        .rstn       (rstn),
        .async_in   (ext_count_pin_a),
        .rise_pulse (pin_a_edge)
    );

    sts_sync u_sync_pin_b (
        .ref_clk    (ref_clk),
        .rstn       (rstn),
        .async_in   (ext_count_pin_b),
        .rise_pulse (pin_b_edge)
    );

    // ----------------------------------------------------------------
    // prescaler
    // ----------------------------------------------------------------
    // oscillators are sampled, so each must stay well below a quarter of ref_clk
    assign osc_tick = clk_cfg_reg[`STS_SYS_SUB_SEL] ? sub_edge : main_edge;
    assign div2     = osc_tick &
                      ((pre_reg & `STS_PRE_DIV2_MASK) == `STS_PRE_DIV2_MASK);
    assign div16    = osc_tick &
                      ((pre_reg & `STS_PRE_DIV16_MASK) == `STS_PRE_DIV16_MASK);
    assign div4096  = osc_tick &
                      ((pre_reg & `STS_PRE_DIV4096_MASK) == `STS_PRE_DIV4096_MASK);

    always @(posedge ref_clk) begin
        if (!rstn) begin
            pre_reg <= {`STS_PRE_W{1'b0}};
        end else if (osc_tick) begin
            pre_reg <= pre_reg + {{(`STS_PRE_W-1){1'b0}}, 1'b1};
        end
    end

    // ----------------------------------------------------------------
    // source selection
    // ----------------------------------------------------------------
    always @* begin
        // timer one
        if (!timer_mode_first_reg[`STS_T1_SRC_PRIMARY])
            src[0] = div16;
        else if (timer_mode_first_reg[`STS_T1_SRC_SECONDARY])
            src[0] = pin_a_edge;
        else
            src[0] = div4096;
        // timer two
        if (timer_mode_first_reg[`STS_T2_SRC_PRIMARY])
            src[1] = pin_a_edge;
        else if (timer_mode_first_reg[`STS_T2_SRC_SECONDARY])
            src[1] = overflow[0];
        else
            src[1] = div16;
        // timer three
        if (timer_mode_second_reg[`STS_T3_SRC_LOW])
            src[2] = pin_b_edge;
        else if (t3_ext_reg[`STS_T3_SUB_SEL])
            src[2] = sub_edge;
        else
            src[2] = div16;
        // timer four
        case ({timer_mode_second_reg[`STS_T4_SRC_HIGH],
               timer_mode_second_reg[`STS_T4_SRC_LOW]})
            2'h0: src[3] = overflow[2];
            2'h1: src[3] = div16;
            2'h2: src[3] = div2;
            2'h3: src[3] = sub_edge;
            default: src[3] = 1'b0;
        endcase
        // timer five
        if (!timer_mode_second_reg[`STS_T5_SRC_PRIMARY])
            src[4] = div16;
        else if (timer_mode_first_reg[`STS_T5_SRC_SECONDARY])
            src[4] = overflow[3];
        else
            src[4] = overflow[1];
        // timer six
        if (timer_mode_first_reg[`STS_T6_SRC_INTERNAL])
            src[5] = overflow[4];
        else
            src[5] = div16;
        // halt bits
        halt[0] = timer_mode_first_reg[`STS_T1_HALT];
        halt[1] = timer_mode_first_reg[`STS_T2_HALT];
        halt[2] = timer_mode_second_reg[`STS_T3_HALT];
        halt[3] = timer_mode_second_reg[`STS_T4_HALT];
        halt[4] = timer_mode_second_reg[`STS_T5_HALT];
        halt[5] = timer_mode_second_reg[`STS_T6_HALT];
        adv = src & ~halt;
    end

    // ----------------------------------------------------------------
    // counters
    // ----------------------------------------------------------------
    // overflows are registered one-cycle pulses, so a chained timer sees
    // each one exactly once at the cost of one cycle of latency per stage
    always @(posedge ref_clk) begin
        if (!rstn) begin
            cnt_reg    <= {(NT*TMR_W){1'b0}};
            count_tick <= {NT{1'b0}};
            overflow   <= {NT{1'b0}};
        end else begin
            for (i = 0; i < NT; i = i + 1) begin
                count_tick[i] <= adv[i];
                overflow[i]   <= adv[i] & (&cnt_reg[i*TMR_W +: TMR_W]);
                if (adv[i]) begin
                    cnt_reg[i*TMR_W +: TMR_W] <= cnt_reg[i*TMR_W +: TMR_W] +
                                                 {{(TMR_W-1){1'b0}}, 1'b1};
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // apb slave
    // ----------------------------------------------------------------
    assign idx     = paddr[11:2];
    assign wr_done = psel & penable & pready & pwrite;

    always @* begin
        rd_next  = 32'h0000_0000;
        hit_next = 1'b1;
        cnt_off  = idx - `STS_IDX_CNT_BASE;
        case (idx)
            `STS_IDX_MODE1:  rd_next[7:0] = timer_mode_first_reg;
            `STS_IDX_MODE2:  rd_next[7:0] = timer_mode_second_reg;
            `STS_IDX_T3EXT:  rd_next[7:0] = t3_ext_reg;
            `STS_IDX_CLKCFG: rd_next[7:0] = clk_cfg_reg;
            default: begin
                hit_next = 1'b0;
                for (j = 0; j < NT; j = j + 1) begin
                    if (cnt_off == j[9:0]) begin
                        hit_next            = 1'b1;
                        rd_next[TMR_W-1:0]  = cnt_reg[j*TMR_W +: TMR_W];
                    end
                end
            end
        endcase
    end

    // one wait state: answer in the second access cycle
    always @(posedge ref_clk) begin
        if (!rstn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else if (psel & penable & ~pready) begin
            pready  <= 1'b1;
            pslverr <= ~hit_next;
            prdata  <= pwrite ? 32'h0000_0000 : rd_next;
        end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end
    end

    always @(posedge ref_clk) begin
        if (!rstn) begin
            timer_mode_first_reg  <= `STS_RST_MODE1;
            timer_mode_second_reg <= `STS_RST_MODE2;
            t3_ext_reg            <= `STS_RST_T3EXT;
            clk_cfg_reg           <= `STS_RST_CLKCFG;
        end else if (wr_done) begin
            case (idx)
                `STS_IDX_MODE1:  timer_mode_first_reg  <= pwdata[7:0];
                `STS_IDX_MODE2:  timer_mode_second_reg <= pwdata[7:0];
                `STS_IDX_T3EXT:  t3_ext_reg[`STS_T3_SUB_SEL] <= pwdata[`STS_T3_SUB_SEL];
                `STS_IDX_CLKCFG: clk_cfg_reg[`STS_SYS_SUB_SEL] <= pwdata[`STS_SYS_SUB_SEL];
                default: begin
                end
            endcase
        end
    end

endmodule
